/* common/host_port_pkg.sv */
// Package: constants, types and encodings for the host port block
package host_port_pkg;

   // ****************************************
   // Host-side register select addresses
   // ****************************************
   localparam logic [2:0] ADDR_CONTROL  = 3'h0;
   localparam logic [2:0] ADDR_CMD_VEC  = 3'h1;
   localparam logic [2:0] ADDR_STATUS   = 3'h2;
   localparam logic [2:0] ADDR_ACK_VEC  = 3'h3;
   localparam logic [2:0] ADDR_UNUSED   = 3'h4;
   localparam logic [2:0] ADDR_TX_HIGH  = 3'h5;
   localparam logic [2:0] ADDR_TX_MID   = 3'h6;
   localparam logic [2:0] ADDR_TX_LOW   = 3'h7;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CTRL_TRANSMIT_REQUEST_ENABLE_POS   = 0;
   localparam int CTRL_SEM0_POS   = 3;
   localparam int CTRL_INIT_POS   = 7;
   localparam int CVR_HC_POS      = 7;
   localparam int STAT_TRANSMIT_EMPTY_FLAG_POS   = 1;
   localparam int STAT_TRDY_POS   = 2;
   localparam int STAT_SERVICE_REQUEST_PIN_POS   = 7;

   // ****************************************
   // Reset values and vectors
   // ****************************************
   localparam logic [4:0]  CMD_VEC_RESET    = 5'h12;
   localparam logic [7:0]  ACK_VEC_RESET    = 8'h0F;
   localparam logic [15:0] VEC_RECEIVE      = 16'h0020;
   localparam logic [15:0] VEC_TRANSMIT     = 16'h0022;
   localparam logic [15:0] VEC_CMD_LOW      = 16'h0024;
   localparam logic [15:0] VEC_CMD_HIGH     = 16'h003C;
   localparam logic [15:0] VEC_MULTIPLIER   = 16'h0002;

   // ****************************************
   // Synchroniser depth for pins
   // ****************************************
   localparam int SYNC_STAGES = 3;

   // ****************************************
   // Strobe tracking state
   // ****************************************
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_ACTIVE = 2'b01,
      ST_FINISH = 2'b11
   } strobe_state_t;

   // Host pin bundle (synchronised view)
   typedef struct packed {
      logic       enable;
      logic       read;
      logic [2:0] sel;
      logic       ack;
   } host_pins_t;

   // Core exception request
   typedef struct packed {
      logic        valid;
      logic [15:0] vector;
   } core_exc_t;

endpackage : host_port_pkg

/* logic/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
module pin_sync #(
   parameter int          WIDTH      = 1,
   parameter logic [31:0] RESET_BITS = 32'h0000_0000
) (
   input  wire logic             clk_sys_i,
   input  wire logic             arst_n_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;
   logic [WIDTH-1:0] stage3_q;
   logic [WIDTH-1:0] level_q;

   // Shift chain; first stage only feeds the second
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         stage1_q <= RESET_BITS[WIDTH-1:0];
         stage2_q <= RESET_BITS[WIDTH-1:0];
         stage3_q <= RESET_BITS[WIDTH-1:0];
      end else begin
         stage1_q <= async_i;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
      end
   end

   // Per bit: change accepted once stages two and three agree
   genvar i;
   for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            level_q[i] <= RESET_BITS[i];
         end else if (stage2_q[i] == stage3_q[i]) begin
            level_q[i] <= stage3_q[i];
         end
      end
   end

   assign sync_o = level_q;

endmodule : pin_sync

/* logic/host_port_block.sv */
// Host port block: host-to-core data path and host command logic
// Behaviour
// - Transmit-empty flag set whenever the transmit byte registers can take bytes.
// - With transmit request enabled, request pin asserted while transmit-empty is set.
// - Host write of the low transmit byte clears transmit-empty.
// - Receive-full flag set while a word waits in the core receive register.
// - Core read of receive register clears receive-full; the transfer of a waiting word then sets transmit-empty.
// - Both flags clear: copy transmit bytes to receive register, set receive-full.
// - Receive interrupt enable and receive-full request exception at vector 0020.
// - Sources: receive 0020, transmit 0022, host command 0000 to 003E.
// - Command exception vector is the command vector number times two.
// - Reset sets command vector number to 12 hex, vector 0024.
// - Host command bit set raises the command-pending bit for the core.
// - Command exception starts only with command interrupt enable and a pending command.
// - Core acceptance clears the host command bit, readable by the host.
// - Host command bit and vector number are written in one write.
// - Host may cancel a pending command before acceptance; it is then not taken.
// - Initialize bit clears itself after execution and on core reset.
// - Request pin released once the satisfying transfer has completed.
// - Host writes captured on the enable rising edge; reads driven from falling edge.
// - Request and acknowledge both asserted: acknowledge vector register drives the bus.
module host_port_block (
   input  wire logic        clk_sys_i,
   input  wire logic        arst_n_i,
   // Host pins
   input  wire logic        port_enable_strobe_n_i,
   input  wire logic        direction_select_pin_i,
   input  wire logic [2:0]  register_select_lines_i,
   input  wire logic        acknowledge_strobe_pin_n_i,
   input  wire logic [7:0]  host_data_i,
   output logic      [7:0]  host_data_o,
   output logic             host_data_oe_n_o,
   output logic             service_request_pin_o,
   output logic             service_request_pin_oe_n_o,
   // Core side
   input  wire logic        port_select_i,
   input  wire logic        receive_interrupt_enable_i,
   input  wire logic        transmit_interrupt_enable_i,
   input  wire logic        command_interrupt_enable_i,
   input  wire logic        transmit_data_empty_i,
   input  wire logic        core_receive_read_i,
   input  wire logic        exception_accept_i,
   output logic      [23:0] core_receive_register_o,
   output logic             core_receive_full_flag_o,
   output logic             command_pending_bit_o,
   output logic             general_semaphore_zero_o,
   output logic             exception_request_o,
   output logic      [15:0] exception_vector_o
);

   // ****************************************
   // Pin synchronisation
   // ****************************************
   // Raw and synchronised pin views
   host_port_pkg::host_pins_t pins_raw;
   host_port_pkg::host_pins_t pins;
   logic [7:0] data_sync;

   // Active-high view of the host pins
   assign pins_raw.enable = ~port_enable_strobe_n_i;
   assign pins_raw.read   = direction_select_pin_i;
   assign pins_raw.sel    = register_select_lines_i;
   assign pins_raw.ack    = ~acknowledge_strobe_pin_n_i;

   // Control pins and data bus pass one shared synchroniser
   pin_sync #(
      .WIDTH      (14),
      .RESET_BITS (32'h0000_0000)
   ) u_sync (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .async_i   ({pins_raw, host_data_i}),
      .sync_o    ({pins, data_sync})
   );

   // ****************************************
   // Strobe edge tracking
   // ****************************************
   // Strobe state and captured access context
   host_port_pkg::strobe_state_t state_q;
   host_port_pkg::strobe_state_t state_d;
   logic       access_read_q;
   logic [2:0] access_sel_q;
   logic       write_done;
   logic       read_start;
   logic       read_done;

   // Enable strobe sequencing
   always_comb begin
      state_d = state_q;
      case (state_q)
         host_port_pkg::ST_IDLE: begin
            if (pins.enable) begin
               state_d = host_port_pkg::ST_ACTIVE;
            end
         end
         host_port_pkg::ST_ACTIVE: begin
            if (!pins.enable) begin
               state_d = host_port_pkg::ST_FINISH;
            end
         end
         host_port_pkg::ST_FINISH: begin
            state_d = host_port_pkg::ST_IDLE;
         end
         default: begin
            state_d = host_port_pkg::ST_IDLE;
         end
      endcase
   end

   // Access context captured while strobe falls
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q       <= host_port_pkg::ST_IDLE;
         access_read_q <= 1'b0;
         access_sel_q  <= 3'h0;
      end else begin
         state_q <= state_d;
         if (state_q == host_port_pkg::ST_IDLE && pins.enable) begin
            access_read_q <= pins.read;
            access_sel_q  <= pins.sel;
         end
      end
   end

   // Strobe events: read launch, write capture, read end
   assign read_start = (state_q == host_port_pkg::ST_IDLE) && pins.enable && pins.read;
   assign write_done = (state_q == host_port_pkg::ST_ACTIVE) && !pins.enable && !access_read_q;
   assign read_done  = (state_q == host_port_pkg::ST_ACTIVE) && !pins.enable && access_read_q;

   // ****************************************
   // Host-side registers
   // ****************************************
   // Host-visible register state
   logic       transmit_request_enable_q;
   logic       rreq_q;
   logic       sem0_q;
   logic       init_q;
   logic       host_cmd_q;
   logic [4:0] cmd_vec_q;
   logic [7:0] ack_vec_q;
   logic [7:0] tx_high_q;
   logic [7:0] tx_mid_q;
   logic [7:0] tx_low_q;
   logic       tx_empty_q;
   logic       rx_full_q;
   logic       transfer;
   logic       accept_cmd;

   // Host control register; initialize bit is self clearing
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         transmit_request_enable_q <= 1'b0;
         rreq_q <= 1'b0;
         sem0_q <= 1'b0;
         init_q <= 1'b0;
      end else if (write_done && access_sel_q == host_port_pkg::ADDR_CONTROL) begin
         transmit_request_enable_q <= data_sync[host_port_pkg::CTRL_TRANSMIT_REQUEST_ENABLE_POS];
         rreq_q <= data_sync[host_port_pkg::CTRL_TRANSMIT_REQUEST_ENABLE_POS + 1];
         sem0_q <= data_sync[host_port_pkg::CTRL_SEM0_POS];
         init_q <= data_sync[host_port_pkg::CTRL_INIT_POS];
      end else if (init_q) begin
         init_q <= 1'b0;
      end
   end

   // Command vector: bit and number in one write; acceptance clears the bit
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         host_cmd_q <= 1'b0;
         cmd_vec_q  <= host_port_pkg::CMD_VEC_RESET;
      end else if (write_done && access_sel_q == host_port_pkg::ADDR_CMD_VEC) begin
         host_cmd_q <= data_sync[host_port_pkg::CVR_HC_POS];
         cmd_vec_q  <= data_sync[4:0];
      end else if (accept_cmd) begin
         host_cmd_q <= 1'b0;
      end
   end

   // Acknowledge vector register
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ack_vec_q <= host_port_pkg::ACK_VEC_RESET;
      end else if (write_done && access_sel_q == host_port_pkg::ADDR_ACK_VEC) begin
         ack_vec_q <= data_sync;
      end
   end

   // Transmit byte registers
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_high_q <= 8'h00;
         tx_mid_q  <= 8'h00;
         tx_low_q  <= 8'h00;
      end else if (write_done) begin
         case (access_sel_q)
            host_port_pkg::ADDR_TX_HIGH: tx_high_q <= data_sync;
            host_port_pkg::ADDR_TX_MID:  tx_mid_q  <= data_sync;
            host_port_pkg::ADDR_TX_LOW:  tx_low_q  <= data_sync;
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // Handshake flags and word transfer
   // ****************************************
   // Word moves across once both flags are clear
   assign transfer = !tx_empty_q && !rx_full_q;

   // Transmit-empty: low byte write clears, transfer sets
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_empty_q <= 1'b1;
      end else if (transfer) begin
         tx_empty_q <= 1'b1;
      end else if (write_done && access_sel_q == host_port_pkg::ADDR_TX_LOW) begin
         tx_empty_q <= 1'b0;
      end
   end

   // Receive-full: transfer sets, core read clears; set wins
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rx_full_q <= 1'b0;
      end else if (transfer) begin
         rx_full_q <= 1'b1;
      end else if (core_receive_read_i) begin
         rx_full_q <= 1'b0;
      end
   end

   // Core receive register loaded from the byte group
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         core_receive_register_o <= 24'h00_0000;
      end else if (transfer) begin
         core_receive_register_o <= {tx_high_q, tx_mid_q, tx_low_q};
      end
   end

   // Core-side status views
   assign core_receive_full_flag_o = rx_full_q;
   assign command_pending_bit_o    = host_cmd_q;
   assign general_semaphore_zero_o = sem0_q;

   // ****************************************
   // Core exception requests
   // ****************************************
   logic rx_exc;
   logic tx_exc;
   logic cmd_exc;
   host_port_pkg::core_exc_t exc_sel;

   // Enabled sources while the port is selected
   assign rx_exc  = port_select_i && receive_interrupt_enable_i && rx_full_q;
   assign tx_exc  = port_select_i && transmit_interrupt_enable_i && transmit_data_empty_i;
   assign cmd_exc = port_select_i && command_interrupt_enable_i && host_cmd_q;

   // Command taken only when it is the one presented
   assign accept_cmd = exception_accept_i && cmd_exc && !rx_exc && !tx_exc;

   // Vector selection, receive first, then transmit, then command
   always_comb begin
      exc_sel.valid = rx_exc || tx_exc || cmd_exc;
      if (rx_exc) begin
         exc_sel.vector = host_port_pkg::VEC_RECEIVE;
      end else if (tx_exc) begin
         exc_sel.vector = host_port_pkg::VEC_TRANSMIT;
      end else begin
         exc_sel.vector = 16'({11'h000, cmd_vec_q} * host_port_pkg::VEC_MULTIPLIER);
      end
   end

   // Exception request and vector to the core
   assign exception_request_o = exc_sel.valid;
   assign exception_vector_o  = exc_sel.vector;

   // ****************************************
   // Service request pin
   // ****************************************
   logic req_active;

   // Request from an enabled, empty transmit side
   assign req_active = port_select_i && transmit_request_enable_q && tx_empty_q;

   // Open drain: pull low while requesting
   assign service_request_pin_o      = 1'b0;
   assign service_request_pin_oe_n_o = ~req_active;

   // ****************************************
   // Host read data bus
   // ****************************************
   // Read path state
   logic [7:0] read_mux;
   logic [7:0] status_byte;
   logic       vec_cycle;
   logic       drive_q;
   logic [7:0] data_q;

   // Host status byte and vector fetch detect
   assign status_byte = {req_active, 4'h0, (tx_empty_q && !rx_full_q), tx_empty_q, 1'b0};
   assign vec_cycle   = req_active && pins.ack;

   // Register read mux; unused address reads zero
   always_comb begin
      case (pins.sel)
         host_port_pkg::ADDR_CONTROL: read_mux = {init_q, 3'h0, sem0_q, 1'b0, rreq_q, transmit_request_enable_q};
         host_port_pkg::ADDR_CMD_VEC: read_mux = {host_cmd_q, 2'h0, cmd_vec_q};
         host_port_pkg::ADDR_STATUS:  read_mux = status_byte;
         host_port_pkg::ADDR_ACK_VEC: read_mux = ack_vec_q;
         default:                     read_mux = 8'h00;
      endcase
   end

   // Data driven from strobe fall until release, or during vector cycle
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         drive_q <= 1'b0;
         data_q  <= 8'h00;
      end else if (vec_cycle) begin
         drive_q <= 1'b1;
         data_q  <= ack_vec_q;
      end else if (read_start) begin
         drive_q <= 1'b1;
         data_q  <= read_mux;
      end else if (read_done || !pins.enable) begin
         drive_q <= 1'b0;
      end
   end

   // Bus outputs straight from the drive registers
   assign host_data_o      = data_q;
   assign host_data_oe_n_o = ~drive_q;

endmodule : host_port_block

/* sim/host_port_block_properties.sv */
// Checker: port-level properties of the host port block
module host_port_block_properties (
   input wire logic        clk_sys_i,
   input wire logic        arst_n_i,
   input wire logic        port_enable_strobe_n_i,
   input wire logic        direction_select_pin_i,
   input wire logic        acknowledge_strobe_pin_n_i,
   input wire logic        port_select_i,
   input wire logic        receive_interrupt_enable_i,
   input wire logic        transmit_interrupt_enable_i,
   input wire logic        command_interrupt_enable_i,
   input wire logic        transmit_data_empty_i,
   input wire logic        core_receive_read_i,
   input wire logic        exception_accept_i,
   input wire logic        core_receive_full_flag_o,
   input wire logic        command_pending_bit_o,
   input wire logic        service_request_pin_oe_n_o,
   input wire logic        host_data_oe_n_o,
   input wire logic        exception_request_o,
   input wire logic [15:0] exception_vector_o
);
   // ****************************************
   // Exception sources of higher priority, command gating and command bit, receive flag, bus release and idle properties
   // ****************************************
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!arst_n_i);

   // Receive and transmit requests that outrank a command
   wire logic rx_hit = port_select_i && receive_interrupt_enable_i && core_receive_full_flag_o;
   wire logic tx_hit = port_select_i && transmit_interrupt_enable_i && transmit_data_empty_i;

   property p_rx_clear;
      core_receive_read_i && core_receive_full_flag_o |=> !core_receive_full_flag_o;
   endproperty
   a_rx_clear: assert property (p_rx_clear) else $error("receive flag kept after read");
   property p_rx_exc;
      rx_hit |-> exception_request_o && exception_vector_o == host_port_pkg::VEC_RECEIVE;
   endproperty
   a_rx_exc: assert property (p_rx_exc) else $error("receive exception missing");
   property p_tx_exc;
      tx_hit && !rx_hit |-> exception_request_o && exception_vector_o == host_port_pkg::VEC_TRANSMIT;
   endproperty
   a_tx_exc: assert property (p_tx_exc) else $error("transmit exception missing");
   property p_cmd_gate;
      exception_request_o && !rx_hit && !tx_hit |-> command_interrupt_enable_i && command_pending_bit_o;
   endproperty
   a_cmd_gate: assert property (p_cmd_gate) else $error("command exception without cause");
   property p_cmd_accept;
      exception_accept_i && exception_request_o && !rx_hit && !tx_hit |=> !command_pending_bit_o;
   endproperty
   a_cmd_accept: assert property (p_cmd_accept) else $error("command bit kept after accept");
   property p_cmd_set;
      $rose(command_pending_bit_o) |-> port_enable_strobe_n_i && !direction_select_pin_i;
   endproperty
   a_cmd_set: assert property (p_cmd_set) else $error("command bit set without host write");
   property p_bus_release;
      (port_enable_strobe_n_i && acknowledge_strobe_pin_n_i) [*8] |-> host_data_oe_n_o;
   endproperty
   a_bus_release: assert property (p_bus_release) else $error("data bus driven while idle");
   property p_idle;
      !port_select_i |-> service_request_pin_oe_n_o && !exception_request_o;
   endproperty
   a_idle: assert property (p_idle) else $error("request while port disabled");
endmodule : host_port_block_properties

bind host_port_block host_port_block_properties chk_u (.*);

/* sim/host_model.sv */
// Partner model: external host processor on the port pins
module host_model (
   input  wire logic       clk_sys_i,
   input  wire logic [7:0] read_data_i,
   output logic            strobe_n_o,
   output logic            dir_o,
   output logic [2:0]      sel_o,
   output logic            ack_n_o,
   output logic [7:0]      bus_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle pins, strobes released
   initial begin
      strobe_n_o = 1'b1;
      dir_o = 1'b1;
      sel_o = 3'h0;
      ack_n_o = 1'b1;
      bus_o = 8'h00;
   end

   // One bus cycle: direction and select first, then strobe, data held past release
   task automatic access(input logic rd, input logic [2:0] sel, input logic [7:0] wd, output logic [7:0] q);
      @(negedge clk_sys_i);
      dir_o = rd;
      sel_o = sel;
      bus_o = rd ? ~bus_o : wd;
      @(negedge clk_sys_i);
      strobe_n_o = 1'b0;
      repeat (8) @(negedge clk_sys_i);
      q = read_data_i;
      strobe_n_o = 1'b1;
      repeat (6) @(negedge clk_sys_i);
      bus_o = ~bus_o;
      repeat (4) @(negedge clk_sys_i);
   endtask : access

   // Word of n bytes, high first, low byte always last
   task automatic send_word(input int n, input logic [23:0] w);
      logic [7:0] q;
      for (int i = 3 - n; i < 3; i++) access(1'b0, 3'(i + 5), w[23 - 8 * i -: 8], q);
   endtask : send_word

   // Vector fetch with acknowledge
   task automatic ack_cycle(output logic [7:0] q);
      @(negedge clk_sys_i);
      ack_n_o = 1'b0;
      repeat (6) @(negedge clk_sys_i);
      q = read_data_i;
      ack_n_o = 1'b1;
      repeat (10) @(negedge clk_sys_i);
   endtask : ack_cycle
endmodule : host_model

/* sim/testbench.sv */
// Testbench: host writes, core reads and host commands
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_sys_i = 1'b0, arst_n_i = 1'b0;
   logic        port_enable_strobe_n_i, direction_select_pin_i, acknowledge_strobe_pin_n_i;
   logic [2:0]  register_select_lines_i;
   logic [7:0]  host_data_i, host_data_o, rd;
   logic        host_data_oe_n_o, service_request_pin_o, service_request_pin_oe_n_o;
   logic        port_select_i = 1'b0, receive_interrupt_enable_i = 1'b0, transmit_interrupt_enable_i = 1'b0;
   logic        command_interrupt_enable_i = 1'b0, transmit_data_empty_i = 1'b0;
   logic        core_receive_read_i = 1'b0, exception_accept_i = 1'b0;
   logic [23:0] core_receive_register_o;
   logic        core_receive_full_flag_o, command_pending_bit_o, general_semaphore_zero_o, exception_request_o;
   logic [15:0] exception_vector_o;
   int          bad_count = 0, check_count = 0, cycles = 0;

   // ****************************************
   // Clock, design and host
   // ****************************************
   always #10 clk_sys_i = ~clk_sys_i;

   host_port_block dut_u (.*);
   host_model host_u (.clk_sys_i, .read_data_i(host_data_oe_n_o ? ~host_data_o : host_data_o),
      .strobe_n_o(port_enable_strobe_n_i), .dir_o(direction_select_pin_i), .sel_o(register_select_lines_i),
      .ack_n_o(acknowledge_strobe_pin_n_i), .bus_o(host_data_i));

   // Comparisons
   task automatic check_flag(input string what, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask : check_flag

   task automatic check_word(input string what, input logic [23:0] exp, input logic [23:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word

   // One-cycle core strobe: accept or receive read
   task automatic core_pulse(input logic accept);
      @(negedge clk_sys_i);
      exception_accept_i = accept;
      core_receive_read_i = !accept;
      @(negedge clk_sys_i);
      exception_accept_i = 1'b0;
      core_receive_read_i = 1'b0;
   endtask : core_pulse

   task automatic t_reset;
      check_flag("rx full", 1'b0, core_receive_full_flag_o);
      check_flag("cmd pending", 1'b0, command_pending_bit_o);
      host_u.access(1'b1, host_port_pkg::ADDR_CMD_VEC, 8'h00, rd);
      check_word("vector number", 24'h00_0012, {19'h0, rd[4:0]});
      host_u.access(1'b1, host_port_pkg::ADDR_STATUS, 8'h00, rd);
      check_flag("tx empty", 1'b1, rd[host_port_pkg::STAT_TRANSMIT_EMPTY_FLAG_POS]);
   endtask : t_reset

   task automatic t_init;
      @(negedge clk_sys_i);
      port_select_i = 1'b1;
      host_u.access(1'b0, host_port_pkg::ADDR_CMD_VEC, 8'h12, rd);
      host_u.access(1'b0, host_port_pkg::ADDR_CONTROL, 8'h89, rd);
      check_flag("semaphore", 1'b1, general_semaphore_zero_o);
      host_u.access(1'b1, host_port_pkg::ADDR_CONTROL, 8'h00, rd);
      check_flag("init bit", 1'b0, rd[host_port_pkg::CTRL_INIT_POS]);
      check_flag("request oe_n", 1'b0, service_request_pin_oe_n_o);
      check_flag("request level", 1'b0, service_request_pin_o);
      host_u.ack_cycle(rd);
      check_word("ack vector", {16'h0000, host_port_pkg::ACK_VEC_RESET}, {16'h0000, rd});
   endtask : t_init

   task automatic t_word;
      host_u.send_word(3, 24'h12_3456);
      check_flag("rx full", 1'b1, core_receive_full_flag_o);
      check_word("rx word", 24'h12_3456, core_receive_register_o);
      host_u.send_word(1, 24'h00_00AB);
      check_flag("request oe_n", 1'b1, service_request_pin_oe_n_o);
      host_u.access(1'b1, host_port_pkg::ADDR_STATUS, 8'h00, rd);
      check_flag("tx empty", 1'b0, rd[host_port_pkg::STAT_TRANSMIT_EMPTY_FLAG_POS]);
      check_word("rx word held", 24'h12_3456, core_receive_register_o);
      core_pulse(1'b0);
      check_flag("rx full", 1'b0, core_receive_full_flag_o);
      @(negedge clk_sys_i);
      check_word("rx word", 24'h12_34AB, core_receive_register_o);
      check_flag("request oe_n", 1'b0, service_request_pin_oe_n_o);
      receive_interrupt_enable_i = 1'b1;
      @(negedge clk_sys_i);
      check_word("rx vector", {8'h00, host_port_pkg::VEC_RECEIVE}, {8'h00, exception_vector_o});
      core_pulse(1'b0);
      receive_interrupt_enable_i = 1'b0;
      transmit_interrupt_enable_i = 1'b1;
      transmit_data_empty_i = 1'b1;
      @(negedge clk_sys_i);
      check_word("tx vector", {8'h00, host_port_pkg::VEC_TRANSMIT}, {8'h00, exception_vector_o});
      transmit_interrupt_enable_i = 1'b0;
      transmit_data_empty_i = 1'b0;
   endtask : t_word

   task automatic t_cmd;
      host_u.access(1'b0, host_port_pkg::ADDR_CMD_VEC, 8'h85, rd);
      check_flag("cmd pending", 1'b1, command_pending_bit_o);
      check_flag("cmd masked", 1'b0, exception_request_o);
      command_interrupt_enable_i = 1'b1;
      @(negedge clk_sys_i);
      check_word("cmd vector", 24'h00_000A, {8'h00, exception_vector_o});
      core_pulse(1'b1);
      check_flag("cmd pending", 1'b0, command_pending_bit_o);
      host_u.access(1'b1, host_port_pkg::ADDR_CMD_VEC, 8'h00, rd);
      check_flag("cmd bit", 1'b0, rd[host_port_pkg::CVR_HC_POS]);
      command_interrupt_enable_i = 1'b0;
      host_u.access(1'b0, host_port_pkg::ADDR_CMD_VEC, 8'h86, rd);
      host_u.access(1'b0, host_port_pkg::ADDR_CMD_VEC, 8'h06, rd);
      command_interrupt_enable_i = 1'b1;
      @(negedge clk_sys_i);
      check_flag("cancelled cmd", 1'b0, exception_request_o);
      host_u.access(1'b0, host_port_pkg::ADDR_CMD_VEC, 8'h9E, rd);
      check_word("cmd vector", {8'h00, host_port_pkg::VEC_CMD_HIGH}, {8'h00, exception_vector_o});
      core_pulse(1'b1);
   endtask : t_cmd

   // Verdict and end of run
   task automatic conclude;
      $display("Checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : conclude

   // Hang guard
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 2000) begin
         bad_count++;
         conclude();
      end
   end

   // Main sequence
   initial begin
      repeat (2) @(negedge clk_sys_i);
      arst_n_i = 1'b1;
      t_reset();
      t_init();
      t_word();
      t_cmd();
      conclude();
   end
endmodule : testbench
